// ### src/srtc_pkg.sv
package srtc_pkg;

    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_CMD        = 16'hB798;
    localparam logic [15:0] IDX_STATUS     = 16'hB7A2;
    localparam logic [15:0] IDX_START      = 16'hB7B6;
    localparam logic [15:0] IDX_EDGE       = 16'hB7CA;
    localparam logic [15:0] IDX_QUEUE      = 16'hB7C0;
    localparam logic [15:0] IDX_IRQ_STAT   = 16'hB7D0;
    localparam logic [15:0] IDX_IRQ_MASK   = 16'hB7D1;

    localparam int          ADDR_W         = 18;
    localparam logic [17:0] ADDR_CMD       = {IDX_CMD, 2'b00};
    localparam logic [17:0] ADDR_STATUS    = {IDX_STATUS, 2'b00};
    localparam logic [17:0] ADDR_START     = {IDX_START, 2'b00};
    localparam logic [17:0] ADDR_EDGE      = {IDX_EDGE, 2'b00};
    localparam logic [17:0] ADDR_QUEUE     = {IDX_QUEUE, 2'b00};
    localparam logic [17:0] ADDR_IRQ_STAT  = {IDX_IRQ_STAT, 2'b00};
    localparam logic [17:0] ADDR_IRQ_MASK  = {IDX_IRQ_MASK, 2'b00};

    // command codes
    localparam logic [31:0] COUNTER_CLEAR_CMD     = 32'h0000_0000;
    localparam logic [31:0] STAMPING_OFF_CMD      = 32'h0000_000A;
    localparam logic [31:0] SECONDS_REFERENCE_CMD = 32'h0000_000D;

    // edge select codes
    localparam logic [31:0] RISING_EDGE_SELECT    = 32'h0000_000A;
    localparam logic [31:0] FALLING_EDGE_SELECT   = 32'h0000_0014;

    // fifo status codes
    localparam logic [1:0]  QUEUE_VACANT     = 2'h0;
    localparam logic [1:0]  QUEUE_BELOW_HALF = 2'h1;
    localparam logic [1:0]  QUEUE_ABOVE_HALF = 2'h2;
    localparam logic [1:0]  QUEUE_OVERRUN    = 2'h3;

    // interrupt status / mask layout
    localparam int          IRQ_W       = 3;
    localparam int          IRQ_SEC_BIT = 0;
    localparam int          IRQ_OVR_BIT = 1;
    localparam int          IRQ_CAP_BIT = 2;

    localparam logic [31:0] MODE_RESET  = STAMPING_OFF_CMD;
    localparam logic [31:0] EDGE_RESET  = RISING_EDGE_SELECT;

endpackage

// ### src/srtc_pulse_edge.sv
`timescale 1ns/1ps
module srtc_pulse_edge (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic pulse_in,
    output logic      rise,
    output logic      fall
);
    logic sync1_r;
    logic sync2_r;
    logic prev_r;

    // two-flop synchroniser, third flop for edge detection
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r  <= 1'b0;
        end else begin
            sync1_r <= pulse_in;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    assign rise = sync2_r & ~prev_r;
    assign fall = ~sync2_r & prev_r;
endmodule

// ### src/srtc_counter.sv
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module srtc_counter
    import srtc_pkg::*;
#(
    parameter int DEPTH  = 65536,
    parameter int SAMP_W = 32,
    parameter int SEC_W  = 24
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [31:0]       wr_data,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    output logic      [31:0]       rd_data,
    input  wire logic              sec_pulse_in,
    input  wire logic              trig_pulse,
    input  wire logic              gated_mode,
    input  wire logic              gate_open,
    input  wire logic [31:0]       epoch_now,
    output logic                   irq
);
    localparam int          AW      = $clog2(DEPTH);
    localparam int          STAMP_W = SAMP_W + SEC_W;
    localparam logic [AW:0] HALF    = (AW+1)'(DEPTH / 2);
    localparam logic [AW:0] FULL    = (AW+1)'(DEPTH);

    logic               rise;
    logic               fall;
    logic               sec_edge;
    logic [31:0]        mode_r;
    logic [31:0]        edge_sel_r;
    logic [31:0]        start_time_r;
    logic               sync_wait_r;
    logic [SAMP_W-1:0]  samp_r;
    logic [SEC_W-1:0]   sec_r;
    logic               gate_d_r;
    logic               gate_edge;
    logic               cap;
    logic               push;
    logic               pop;
    logic               empty;
    logic               full;
    logic               overrun_r;
    logic [AW-1:0]      wr_ptr_r;
    logic [AW-1:0]      rd_ptr_r;
    logic [AW:0]        count_r;
    logic               word_hi_r;
    logic [STAMP_W-1:0] mem [DEPTH];
    logic [1:0]         queue_state;
    logic [IRQ_W-1:0]   irq_stat_r;
    logic [IRQ_W-1:0]   irq_mask_r;
    logic [IRQ_W-1:0]   irq_ev;
    logic [IRQ_W-1:0]   irq_clr;
    logic [31:0]        rd_data_r;
    logic               wr_cmd;
    logic               clear_cmd;
    logic               ref_mode;
    logic               rd_queue;

    srtc_pulse_edge srtc_pulse_edge_i (
        .clk      (clk),
        .rst_b    (rst_b),
        .pulse_in (sec_pulse_in),
        .rise     (rise),
        .fall     (fall)
    );

    assign wr_cmd    = wr_en && (addr == ADDR_CMD);
    assign clear_cmd = wr_cmd && (wr_data == COUNTER_CLEAR_CMD);
    assign ref_mode  = (mode_r == SECONDS_REFERENCE_CMD);
    assign sec_edge  = (edge_sel_r == FALLING_EDGE_SELECT) ? fall : rise;

    // other codes, the clear among them, leave the mode as it is
    // mode switching
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mode_r <= MODE_RESET;
        end else if (wr_cmd) begin
            // selecting the mode leaves the counter alone
            if (wr_data == SECONDS_REFERENCE_CMD || wr_data == STAMPING_OFF_CMD) begin
                mode_r <= wr_data;
            end
        end
    end

    // edge select register, unknown codes ignored
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            edge_sel_r <= EDGE_RESET;
        end else if (wr_en && addr == ADDR_EDGE) begin
            if (wr_data == RISING_EDGE_SELECT || wr_data == FALLING_EDGE_SELECT) begin
                edge_sel_r <= wr_data;
            end
        end
    end

    // counting runs in every mode; only capture looks at the mode
    // split counter driven by the seconds pulse
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync_wait_r <= 1'b1;
            samp_r      <= '0;
            sec_r       <= '0;
        end else if (clear_cmd) begin
            // clear acts regardless of edge selection
            sync_wait_r <= 1'b1;
            samp_r      <= '0;
            sec_r       <= '0;
        end else if (sec_edge) begin
            // first edge starts counting from zero
            sync_wait_r <= 1'b0;
            samp_r      <= '0;
            if (!sync_wait_r) begin
                sec_r <= sec_r + SEC_W'(1);
            end
        end else if (!sync_wait_r) begin
            samp_r <= samp_r + SAMP_W'(1);
        end
    end

    // a clear in the same cycle as the edge wins, so no start time is taken
    // latch wall time at the synchronising edge
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            start_time_r <= '0;
        end else if (sec_edge && sync_wait_r && !clear_cmd) begin
            start_time_r <= epoch_now;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            gate_d_r <= 1'b0;
        end else begin
            gate_d_r <= gate_open;
        end
    end

    // a change of the gate level marks a segment start or end
    assign gate_edge = (gate_open != gate_d_r);

    // gated mode stamps both gate edges
    // nothing captured unless the reference mode is active
    assign cap = ref_mode && !sync_wait_r &&
                 (gated_mode ? gate_edge : trig_pulse);

    assign empty    = (count_r == '0);
    assign full     = (count_r == FULL);
    assign rd_queue = rd_en && (addr == ADDR_QUEUE);
    assign push     = cap && !full;
    assign pop      = rd_queue && word_hi_r && !empty;

    // storage needs no reset: only entries below the count are ever read
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r] <= {sec_r, samp_r};
        end
    end

    // pointers wrap at the depth, so the depth must be a power of two
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + AW'(1);
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + AW'(1);
            end
            if (push && !pop) begin
                count_r <= count_r + (AW+1)'(1);
            end else if (pop && !push) begin
                count_r <= count_r - (AW+1)'(1);
            end
        end
    end

    // a full queue keeps its entries; later stamps are dropped and flagged
    // loss flag, set wins over the clear command
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            overrun_r <= 1'b0;
        end else if (cap && full) begin
            overrun_r <= 1'b1;
        end else if (clear_cmd) begin
            overrun_r <= 1'b0;
        end
    end

    // the entry is popped only with its seconds word, so pairs stay aligned
    // low word first, then seconds word
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            word_hi_r <= 1'b0;
        end else if (rd_queue && !empty) begin
            word_hi_r <= ~word_hi_r;
        end
    end

    // exactly half full still reads as below half
    // fill level code
    always_comb begin
        if (full || overrun_r) begin
            queue_state = QUEUE_OVERRUN;
        end else if (empty) begin
            queue_state = QUEUE_VACANT;
        end else if (count_r > HALF) begin
            queue_state = QUEUE_ABOVE_HALF;
        end else begin
            queue_state = QUEUE_BELOW_HALF;
        end
    end

    // interrupt events: seconds edge, stamp lost, stamp stored
    always_comb begin
        irq_ev              = '0;
        irq_ev[IRQ_SEC_BIT] = sec_edge;
        irq_ev[IRQ_OVR_BIT] = cap && full;
        irq_ev[IRQ_CAP_BIT] = push;
    end

    assign irq_clr = (wr_en && addr == ADDR_IRQ_STAT) ? wr_data[IRQ_W-1:0] : '0;

    // sticky events, write one to clear, set wins
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_mask_r <= '0;
        end else if (wr_en && addr == ADDR_IRQ_MASK) begin
            irq_mask_r <= wr_data[IRQ_W-1:0];
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rd_data_r <= '0;
        end else if (rd_en) begin
            case (addr)
                ADDR_CMD:      rd_data_r <= mode_r;
                ADDR_STATUS:   rd_data_r <= 32'(queue_state);
                ADDR_START:    rd_data_r <= start_time_r;
                ADDR_EDGE:     rd_data_r <= edge_sel_r;
                ADDR_QUEUE: begin
                    if (empty) begin
                        rd_data_r <= '0;
                    end else if (word_hi_r) begin
                        rd_data_r <= 32'(mem[rd_ptr_r][STAMP_W-1:SAMP_W]);
                    end else begin
                        rd_data_r <= 32'(mem[rd_ptr_r][SAMP_W-1:0]);
                    end
                end
                ADDR_IRQ_STAT: rd_data_r <= 32'(irq_stat_r);
                ADDR_IRQ_MASK: rd_data_r <= 32'(irq_mask_r);
                default:       rd_data_r <= '0;
            endcase
        end else begin
            rd_data_r <= '0;
        end
    end

    assign rd_data = rd_data_r;
endmodule

// ### tb/srtc_monitor.sv
`timescale 1ns/1ps
module srtc_monitor
    import srtc_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_b,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [31:0]       wr_data,
    input wire logic              wr_en,
    input wire logic              rd_en,
    input wire logic [31:0]       rd_data,
    input wire logic              sec_pulse_in,
    input wire logic              trig_pulse,
    input wire logic              gated_mode,
    input wire logic              gate_open,
    input wire logic [31:0]       epoch_now,
    input wire logic              irq
);
    logic [31:0] edge_shadow_r;

    // shadow of the last accepted edge select code
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            edge_shadow_r <= EDGE_RESET;
        end else if (wr_en && addr == ADDR_EDGE
                     && (wr_data == RISING_EDGE_SELECT || wr_data == FALLING_EDGE_SELECT)) begin
            edge_shadow_r <= wr_data;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_cmd_reads_mode: assert property (
        rd_en && addr == ADDR_CMD |=>
        rd_data == STAMPING_OFF_CMD || rd_data == SECONDS_REFERENCE_CMD
    ) else $error("command read is not a mode");
    a_ref_mode_kept: assert property (
        wr_en && addr == ADDR_CMD && wr_data == SECONDS_REFERENCE_CMD
        ##1 rd_en && addr == ADDR_CMD |=> rd_data == SECONDS_REFERENCE_CMD
    ) else $error("reference mode not selected");
    a_off_mode_kept: assert property (
        wr_en && addr == ADDR_CMD && wr_data == STAMPING_OFF_CMD
        ##1 rd_en && addr == ADDR_CMD |=> rd_data == STAMPING_OFF_CMD
    ) else $error("off mode not selected");
    a_edge_written: assert property (
        wr_en && addr == ADDR_EDGE
        && (wr_data == RISING_EDGE_SELECT || wr_data == FALLING_EDGE_SELECT)
        ##1 rd_en && addr == ADDR_EDGE |=> rd_data == $past(wr_data, 2)
    ) else $error("edge select not stored");
    a_clear_keeps_edge: assert property (
        wr_en && addr == ADDR_CMD && wr_data == COUNTER_CLEAR_CMD
        ##1 rd_en && addr == ADDR_EDGE |=>
        rd_data == $past(edge_shadow_r)
    ) else $error("clear disturbed edge select");
    a_status_code: assert property (
        rd_en && addr == ADDR_STATUS |=> rd_data[31:2] == 30'h0
    ) else $error("status outside its codes");
    a_rdata_idle: assert property (
        !$past(rd_en) |-> rd_data == 32'h0
    ) else $error("read data outside read cycle");
    a_irq_masked: assert property (
        wr_en && addr == ADDR_IRQ_MASK && wr_data[IRQ_W-1:0] == '0 |=> !irq
    ) else $error("interrupt with all masked");
endmodule

bind srtc_counter srtc_monitor srtc_monitor_i (.clk(clk), .rst_b(rst_b), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .sec_pulse_in(sec_pulse_in), .trig_pulse(trig_pulse), .gated_mode(gated_mode),
    .gate_open(gate_open), .epoch_now(epoch_now), .irq(irq));

// ### tb/srtc_pulse_src.sv
`timescale 1ns/1ps
module srtc_pulse_src #(
    parameter int PERIOD_NS = 4003
) (
    input  wire logic run,
    output logic      pulse
);
    // scaled seconds pulse, idle low, drifts against the sample clock
    initial begin
        pulse = 1'b0;
        forever begin
            wait (run);
            #3;
            pulse = 1'b1;
            #(PERIOD_NS / 2);
            pulse = 1'b0;
            #(PERIOD_NS / 2);
        end
    end
endmodule

// ### tb/srtc_counter_bench.sv
`timescale 1ns/1ps
module srtc_counter_bench
    import srtc_pkg::*;
;
    localparam int DEPTH = 8;
    localparam int K     = 20;
    logic              clk = 1'b0;
    logic              rst_b = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [31:0]       wr_data = '0;
    logic              wr_en = 1'b0;
    logic              rd_en = 1'b0;
    logic [31:0]       rd_data;
    logic              sec_pulse;
    logic              run = 1'b0;
    logic              trig_pulse = 1'b0;
    logic              gated_mode = 1'b0;
    logic              gate_open = 1'b0;
    logic [31:0]       epoch_now = 32'h1234_5678;
    logic              irq;
    logic [31:0]       d, s1, c1, s2, c2;
    int                num_errors = 0;
    int                checks_done = 0;

    always #4 clk = ~clk;

    srtc_pulse_src srtc_pulse_src_i (.run(run), .pulse(sec_pulse));
    srtc_counter #(.DEPTH(DEPTH)) srtc_counter_i (.clk(clk), .rst_b(rst_b), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .sec_pulse_in(sec_pulse), .trig_pulse(trig_pulse), .gated_mode(gated_mode),
        .gate_open(gate_open), .epoch_now(epoch_now), .irq(irq));

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
        wr_en <= 1'b1; addr <= a; wr_data <= v;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v);
        rd_en <= 1'b1; addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        @(posedge clk);
        v = rd_data;
    endtask
    task automatic trig();
        trig_pulse <= 1'b1;
        @(posedge clk);
        trig_pulse <= 1'b0;
    endtask
    task automatic near_edge(input logic [31:0] s);
        chk("samples after edge", {31'h0, s >= K - 6 && s <= K}, 32'h1);
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        #100000;
        num_errors++;
        end_sim();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(ADDR_CMD, d); chk("mode", d, STAMPING_OFF_CMD);
        rd(ADDR_EDGE, d); chk("edge", d, RISING_EDGE_SELECT);
        rd(ADDR_STATUS, d); chk("status", d, 32'h0);
        rd(ADDR_QUEUE, d); chk("empty queue", d, 32'h0);
        rd(18'h00004, d); chk("unmapped", d, 32'h0);
        wr(ADDR_IRQ_MASK, 32'h1 << IRQ_CAP_BIT);
        @(posedge clk);
        wr(ADDR_CMD, SECONDS_REFERENCE_CMD);
        rd(ADDR_CMD, d); chk("mode", d, SECONDS_REFERENCE_CMD);
        wr(ADDR_CMD, COUNTER_CLEAR_CMD);
        rd(ADDR_CMD, d); chk("mode", d, SECONDS_REFERENCE_CMD);
        trig();
        rd(ADDR_STATUS, d); chk("waiting", d, 32'h0);
        run <= 1'b1;
        @(posedge sec_pulse);
        repeat (K) @(posedge clk);
        trig();
        epoch_now <= 32'h0ABC_DEF0;
        rd(ADDR_STATUS, d); chk("status", d, 32'h1);
        chk("irq", {31'h0, irq}, 32'h1);
        rd(ADDR_QUEUE, s1); near_edge(s1);
        rd(ADDR_QUEUE, c1); chk("seconds", c1, 32'h0);
        rd(ADDR_START, d); chk("start", d, 32'h1234_5678);
        wr(ADDR_IRQ_STAT, 32'h1 << IRQ_CAP_BIT);
        @(posedge clk);
        chk("irq", {31'h0, irq}, 32'h0);
        @(posedge sec_pulse);
        repeat (K) @(posedge clk);
        trig();
        rd(ADDR_QUEUE, s1); near_edge(s1);
        rd(ADDR_QUEUE, c1); chk("seconds", c1, 32'h1);
        wr(ADDR_EDGE, FALLING_EDGE_SELECT);
        rd(ADDR_EDGE, d); chk("edge", d, FALLING_EDGE_SELECT);
        @(negedge sec_pulse);
        repeat (K) @(posedge clk);
        trig();
        rd(ADDR_QUEUE, s1); near_edge(s1);
        rd(ADDR_QUEUE, c1); chk("seconds", c1, 32'h2);
        wr(ADDR_CMD, COUNTER_CLEAR_CMD);
        rd(ADDR_EDGE, d); chk("edge", d, FALLING_EDGE_SELECT);
        trig();
        rd(ADDR_STATUS, d); chk("waiting", d, 32'h0);
        wr(ADDR_EDGE, RISING_EDGE_SELECT);
        @(posedge sec_pulse);
        repeat (K) @(posedge clk);
        rd(ADDR_START, d); chk("start", d, 32'h0ABC_DEF0);
        wr(ADDR_CMD, STAMPING_OFF_CMD);
        rd(ADDR_CMD, d); chk("mode", d, STAMPING_OFF_CMD);
        trig();
        rd(ADDR_STATUS, d); chk("off", d, 32'h0);
        wr(ADDR_CMD, SECONDS_REFERENCE_CMD);
        gated_mode <= 1'b1;
        gate_open <= 1'b1;
        repeat (3) @(posedge clk);
        gate_open <= 1'b0;
        @(posedge clk);
        gated_mode <= 1'b0;
        rd(ADDR_QUEUE, s1); rd(ADDR_QUEUE, c1); rd(ADDR_QUEUE, s2); rd(ADDR_QUEUE, c2);
        chk("gate span", s2 - s1, 32'h3);
        chk("gate seconds", c2, c1);
        for (int i = 1; i <= DEPTH + 1; i++) begin
            trig();
            rd(ADDR_STATUS, d);
            chk("fill", d, i <= DEPTH / 2 ? 32'h1 : (i < DEPTH ? 32'h2 : 32'h3));
        end
        rd(ADDR_QUEUE, s1); rd(ADDR_QUEUE, c1);
        rd(ADDR_STATUS, d); chk("lost", d, 32'h3);
        wr(ADDR_CMD, COUNTER_CLEAR_CMD);
        rd(ADDR_STATUS, d); chk("after clear", d, 32'h2);
        wr(ADDR_IRQ_MASK, 32'h0);
        @(posedge clk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        end_sim();
    end
endmodule
